/* cies_core.sv */
// Purpose: Executes return-from-irq, config load, power-down and literal subtract
// Assumes: One clock per quarter-cycle; software issues opcodes over AXI4-Lite
// Notes: Other opcodes run as four-cycle no-ops that only advance pc_q
`include "cies_cfg.svh"

module cies_core #(
   parameter int unsigned WATCHDOG_CYCLES = `CIES_WATCHDOG_CYCLES,
   parameter int unsigned SUPPLY_SETTLE_CYCLES = `CIES_SUPPLY_SETTLE_CYCLES
) (
   input wire logic clk, // Core clock, 100 MHz
   input wire logic rst_b, // Async reset, active low
   input wire logic [4:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [4:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [12:0] stack_head, // Top of return stack
   input wire logic wake_evt, // Wake from halt, level
   output logic stack_pop_q, // Pop strobe, one cycle
   output logic master_irq_enable_q, // Master interrupt enable
   output logic osc_run_q, // Main oscillator running
   output logic watchdog_reset_q, // Watchdog reset pulse
   output logic [12:0] pc_q // Program counter
);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int TW = `CIES_TIMER_W;
   localparam logic [TW-1:0] WATCHDOG_LIMIT = TW'(WATCHDOG_CYCLES);
   localparam logic [TW-1:0] SUPPLY_LIMIT = TW'(SUPPLY_SETTLE_CYCLES);
   localparam logic [TW-1:0] OSC_LIMIT = TW'(`CIES_OSC_SETTLE_CYCLES);

   generate
      if (WATCHDOG_CYCLES < 1 || WATCHDOG_CYCLES >= (1 << TW)) begin : g_bad_wd
         $error("watchdog count out of range");
      end
      if (SUPPLY_SETTLE_CYCLES < 1 || SUPPLY_SETTLE_CYCLES >= (1 << TW)) begin : g_bad_sup
         $error("supply settle count out of range");
      end
   endgenerate

   cies_pkg::cies_state_t state_q;
   cies_pkg::cies_flags_t flags_q;
   cies_pkg::cies_alu_t alu_out;
   cies_pkg::cies_alu_t alu_q;
   logic [1:0] q_q;
   logic [13:0] opcode_q;
   logic [7:0] acc_q;
   logic [7:0] prescale_cfg_q;
   logic [7:0] lit_q;
   logic watchdog_en_q;
   logic wr_fire;
   logic rd_fire;
   logic wr_ok;
   logic busy;
   logic issue;
   logic op_return;
   logic op_load_cfg;
   logic op_powerdown;
   logic op_litsub;
   logic last_q;
   logic enter_halt;
   logic watchdog_clr;
   logic watchdog_expired;
   logic settle_clr;
   logic settle_run;
   logic settle_expired;
   logic [TW-1:0] settle_limit;
   logic [31:0] rd_word;
   logic rd_ok;

   // Handshake both address and data in one beat
   assign wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
   assign rd_fire = s_axi_arready & s_axi_arvalid;
   assign busy = (state_q != cies_pkg::CIES_IDLE);
   assign wr_ok = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr <= `CIES_PC_OFS);
   // Opcode must arrive in both low lanes to issue
   assign issue = wr_fire && !busy && (s_axi_awaddr == `CIES_INSTR_OFS) && (s_axi_wstrb[1:0] == 2'h3);

   assign op_return = (opcode_q == `CIES_OP_RETURN_IRQ);
   assign op_load_cfg = (opcode_q == `CIES_OP_LOAD_CFG);
   assign op_powerdown = (opcode_q == `CIES_OP_POWERDOWN);
   assign op_litsub = (opcode_q[13:9] == `CIES_OP_LITSUB_HI);
   assign last_q = (q_q == 2'h3);
   assign enter_halt = (state_q == cies_pkg::CIES_EXEC) && last_q && op_powerdown;

   cies_alu u_alu (
      .lit(lit_q),
      .acc(acc_q),
      .out(alu_out)
   );

   // Watchdog keeps running while halted so it can wake the core
   assign watchdog_clr = enter_halt;
   cies_timer #(.W(TW)) u_watchdog_counter (
      .clk(clk),
      .rst_b(rst_b),
      .clr(watchdog_clr),
      .run(watchdog_en_q),
      .limit(WATCHDOG_LIMIT),
      .expired(watchdog_expired)
   );

   // One timer serves both settle waits; they never overlap
   assign settle_clr = (state_q == cies_pkg::CIES_HALT);
   assign settle_run = (state_q == cies_pkg::CIES_PWRUP) || (state_q == cies_pkg::CIES_SETTLE);
   assign settle_limit = (state_q == cies_pkg::CIES_PWRUP) ? SUPPLY_LIMIT : OSC_LIMIT;
   cies_timer #(.W(TW)) u_settle (
      .clk(clk),
      .rst_b(rst_b),
      .clr(settle_clr),
      .run(settle_run),
      .limit(settle_limit),
      .expired(settle_expired)
   );

   // Sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= cies_pkg::CIES_PWRUP;
         q_q <= 2'h0;
      end else begin
         case (state_q)
            cies_pkg::CIES_PWRUP: begin
               if (settle_expired) begin
                  state_q <= cies_pkg::CIES_IDLE;
               end
            end
            cies_pkg::CIES_IDLE: begin
               q_q <= 2'h0;
               if (issue) begin
                  state_q <= cies_pkg::CIES_EXEC;
               end
            end
            cies_pkg::CIES_EXEC: begin
               q_q <= q_q + 2'h1;
               if (last_q) begin
                  if (op_return) begin
                     state_q <= cies_pkg::CIES_EXEC2;
                  end else if (op_powerdown) begin
                     state_q <= cies_pkg::CIES_HALT;
                  end else begin
                     state_q <= cies_pkg::CIES_IDLE;
                  end
               end
            end
            cies_pkg::CIES_EXEC2: begin
               q_q <= q_q + 2'h1;
               if (last_q) begin
                  state_q <= cies_pkg::CIES_IDLE;
               end
            end
            cies_pkg::CIES_HALT: begin
               if (wake_evt || watchdog_expired) begin
                  state_q <= cies_pkg::CIES_SETTLE;
               end
            end
            cies_pkg::CIES_SETTLE: begin
               if (settle_expired) begin
                  state_q <= cies_pkg::CIES_IDLE;
               end
            end
            default: begin
               state_q <= cies_pkg::CIES_IDLE;
            end
         endcase
      end
   end

   // Opcode latch and literal subtract datapath
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         opcode_q <= 14'h0000;
         lit_q <= 8'h00;
         alu_q <= '0;
      end else begin
         if (issue) begin
            opcode_q <= s_axi_wdata[13:0];
         end
         if (state_q == cies_pkg::CIES_EXEC && op_litsub && q_q == 2'h1) begin
            lit_q <= opcode_q[7:0];
         end
         if (state_q == cies_pkg::CIES_EXEC && op_litsub && q_q == 2'h2) begin
            alu_q <= alu_out;
         end
      end
   end

   // Accumulator and prescale config; software writes only while idle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_q <= `CIES_ACC_RST;
         prescale_cfg_q <= `CIES_PRESCALE_CFG_RST;
      end else if (state_q == cies_pkg::CIES_EXEC && last_q) begin
         if (op_litsub) begin
            acc_q <= alu_q.res;
         end
         if (op_load_cfg) begin
            prescale_cfg_q <= acc_q;
         end
      end else if (wr_fire && !busy && s_axi_wstrb[0]) begin
         if (s_axi_awaddr == `CIES_ACC_OFS) begin
            acc_q <= s_axi_wdata[7:0];
         end
         if (s_axi_awaddr == `CIES_PRESCALE_CFG_OFS) begin
            prescale_cfg_q <= s_axi_wdata[7:0];
         end
      end
   end

   // Status flags; only hardware changes them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_q <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1, zero: 1'b0,
                      nibble_borrow_inverse_flag: 1'b0, carry: 1'b0};
      end else begin
         if (state_q == cies_pkg::CIES_EXEC && last_q && op_litsub) begin
            flags_q.carry <= alu_q.carry;
            flags_q.nibble_borrow_inverse_flag <= alu_q.nibble;
            flags_q.zero <= alu_q.zero;
         end
         if (enter_halt) begin
            flags_q.timeout_flag_n <= 1'b1;
            flags_q.powerdown_flag_n <= 1'b0;
         end else if (watchdog_expired) begin
            flags_q.timeout_flag_n <= 1'b0;
         end
      end
   end

   // Program counter, stack pop and interrupt enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_q <= `CIES_PC_RST;
         stack_pop_q <= 1'b0;
         master_irq_enable_q <= 1'b0;
      end else begin
         stack_pop_q <= (state_q == cies_pkg::CIES_EXEC) && last_q && op_return;
         if (state_q == cies_pkg::CIES_EXEC && q_q == 2'h2 && op_return) begin
            master_irq_enable_q <= 1'b1;
         end else if (wr_fire && !busy && s_axi_wstrb[0] && s_axi_awaddr == `CIES_CTRL_OFS) begin
            master_irq_enable_q <= s_axi_wdata[`CIES_CT_IRQ_EN];
         end
         if (state_q == cies_pkg::CIES_EXEC && last_q) begin
            if (op_return) begin
               pc_q <= stack_head;
            end else begin
               pc_q <= pc_q + 13'h0001;
            end
         end
      end
   end

   // Watchdog enable, oscillator run, watchdog reset pulse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         watchdog_en_q <= 1'b0;
         osc_run_q <= 1'b1;
         watchdog_reset_q <= 1'b0;
      end else begin
         if (wr_fire && !busy && s_axi_wstrb[0] && s_axi_awaddr == `CIES_CTRL_OFS) begin
            watchdog_en_q <= s_axi_wdata[`CIES_CT_WATCHDOG_EN];
         end
         if (enter_halt) begin
            osc_run_q <= 1'b0;
         end else if (state_q == cies_pkg::CIES_HALT && (wake_evt || watchdog_expired)) begin
            osc_run_q <= 1'b1;
         end
         // Expiry while halted is a wake, not a reset
         watchdog_reset_q <= watchdog_expired && state_q != cies_pkg::CIES_HALT;
      end
   end

   // AXI write channel
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid & s_axi_wvalid;
         s_axi_wready <= ~s_axi_wready & ~s_axi_bvalid & s_axi_awvalid & s_axi_wvalid;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `CIES_ACC_OFS: rd_word[7:0] = acc_q;
         `CIES_PRESCALE_CFG_OFS: rd_word[7:0] = prescale_cfg_q;
         `CIES_STATUS_OFS: begin
            rd_word[`CIES_ST_CARRY] = flags_q.carry;
            rd_word[`CIES_ST_NIBBLE] = flags_q.nibble_borrow_inverse_flag;
            rd_word[`CIES_ST_ZERO] = flags_q.zero;
            rd_word[`CIES_ST_POWERDOWN_N] = flags_q.powerdown_flag_n;
            rd_word[`CIES_ST_TIMEOUT_N] = flags_q.timeout_flag_n;
            rd_word[`CIES_ST_BUSY] = busy;
            rd_word[`CIES_ST_HALTED] = (state_q == cies_pkg::CIES_HALT);
            rd_word[`CIES_ST_SETTLING] = settle_run;
         end
         `CIES_CTRL_OFS: begin
            rd_word[`CIES_CT_IRQ_EN] = master_irq_enable_q;
            rd_word[`CIES_CT_WATCHDOG_EN] = watchdog_en_q;
         end
         `CIES_INSTR_OFS: rd_word[13:0] = opcode_q;
         `CIES_PC_OFS: rd_word[12:0] = pc_q;
         default: rd_ok = 1'b0;
      endcase
   end

   // AXI read channel
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // cies_core

/* cies_cfg.svh */
// Purpose: Offsets, field positions, reset values, opcodes and timing counts
// Assumes: 100 MHz core clock, one clock per quarter-cycle
// Notes: Shared by the execution unit and its helpers
`ifndef CIES_CFG_SVH
`define CIES_CFG_SVH

// Register byte offsets
`define CIES_ACC_OFS 5'h00
`define CIES_PRESCALE_CFG_OFS 5'h04
`define CIES_STATUS_OFS 5'h08
`define CIES_CTRL_OFS 5'h0C
`define CIES_INSTR_OFS 5'h10
`define CIES_PC_OFS 5'h14

// Status register fields
`define CIES_ST_CARRY 0
`define CIES_ST_NIBBLE 1
`define CIES_ST_ZERO 2
`define CIES_ST_POWERDOWN_N 3
`define CIES_ST_TIMEOUT_N 4
`define CIES_ST_BUSY 5
`define CIES_ST_HALTED 6
`define CIES_ST_SETTLING 7

// Control register fields
`define CIES_CT_IRQ_EN 0
`define CIES_CT_WATCHDOG_EN 1

// Reset values
`define CIES_ACC_RST 8'h00
`define CIES_PRESCALE_CFG_RST 8'hFF
`define CIES_PC_RST 13'h0000

// Opcodes
`define CIES_OP_RETURN_IRQ 14'h0009
`define CIES_OP_LOAD_CFG 14'h0062
`define CIES_OP_POWERDOWN 14'h0063
`define CIES_OP_LITSUB_HI 5'h1E

// Timing
`define CIES_CLK_PERIOD_NS 10
`define CIES_WATCHDOG_MS 18
`define CIES_WATCHDOG_CYCLES (`CIES_WATCHDOG_MS * 1000000 / `CIES_CLK_PERIOD_NS)
`define CIES_SUPPLY_SETTLE_MS 72
`define CIES_SUPPLY_SETTLE_CYCLES (`CIES_SUPPLY_SETTLE_MS * 1000000 / `CIES_CLK_PERIOD_NS)
`define CIES_OSC_SETTLE_PERIODS 1024
`define CIES_OSC_SETTLE_CYCLES (`CIES_OSC_SETTLE_PERIODS * `CIES_CLK_PERIOD_NS / `CIES_CLK_PERIOD_NS)
`define CIES_TIMER_W 24

`endif

/* cies_pkg.sv */
// Purpose: Types shared by the execution unit
// Assumes: Nothing beyond the config header
// Notes: Constants live in cies_cfg.svh
package cies_pkg;

   typedef enum logic [2:0] {
      CIES_PWRUP,
      CIES_IDLE,
      CIES_EXEC,
      CIES_EXEC2,
      CIES_HALT,
      CIES_SETTLE
   } cies_state_t;

   typedef struct packed {
      logic timeout_flag_n;
      logic powerdown_flag_n;
      logic zero;
      logic nibble_borrow_inverse_flag;
      logic carry;
   } cies_flags_t;

   typedef struct packed {
      logic [7:0] res;
      logic carry;
      logic nibble;
      logic zero;
   } cies_alu_t;

endpackage : cies_pkg

/* cies_alu.sv */
// Purpose: Literal minus accumulator with carry, nibble carry and zero
// Assumes: Two's complement 8-bit operands
// Notes: Carry is the inverse of borrow
module cies_alu (
   input wire logic [7:0] lit, // Literal operand
   input wire logic [7:0] acc, // Accumulator operand
   output cies_pkg::cies_alu_t out // Result and flags
);
   logic [8:0] diff;
   logic [4:0] low_diff;

   assign diff = {1'b0, lit} - {1'b0, acc};
   assign low_diff = {1'b0, lit[3:0]} - {1'b0, acc[3:0]};
   assign out.res = diff[7:0];
   assign out.carry = ~diff[8];
   assign out.nibble = ~low_diff[4];
   assign out.zero = (diff[7:0] == 8'h00);
endmodule // cies_alu

/* cies_timer.sv */
// Purpose: Up-counter that pulses after a given number of running cycles
// Assumes: limit is at least one
// Notes: Restarts itself after each expiry
module cies_timer #(
   parameter int W = 24
) (
   input wire logic clk, // Core clock
   input wire logic rst_b, // Async reset, active low
   input wire logic clr, // Restart count
   input wire logic run, // Count this cycle
   input wire logic [W-1:0] limit, // Cycles to expiry
   output logic expired // One-cycle expiry pulse
);
   logic [W-1:0] cnt_q;

   assign expired = run & ~clr & (cnt_q == limit - W'(1));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else if (clr || expired) begin
         cnt_q <= '0;
      end else if (run) begin
         cnt_q <= cnt_q + W'(1);
      end
   end
endmodule // cies_timer

/* cies_props.sv */
// Purpose: Port-level checks on the execution unit
// Assumes: One clock, async active-low reset
// Notes: Bound into cies_core at the foot of this file
module cies_props #(
   parameter int unsigned WATCHDOG_CYCLES = 50
) (
   input wire logic clk, // Core clock
   input wire logic rst_b, // Reset, low
   input wire logic s_axi_awready, // Addr ready
   input wire logic s_axi_wready, // Data ready
   input wire logic s_axi_bvalid, // Resp valid
   input wire logic s_axi_bready, // Resp ready
   input wire logic [1:0] s_axi_bresp, // Resp code
   input wire logic s_axi_arready, // Read addr ready
   input wire logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic wake_evt, // Wake request
   input wire logic stack_pop_q, // Pop strobe
   input wire logic master_irq_enable_q, // Irq enable
   input wire logic osc_run_q, // Osc running
   input wire logic watchdog_reset_q // Watchdog pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [31:0] gap_q;
   // Saturates so a long quiet run never wraps into a false short gap
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_q <= '0;
      end else if (watchdog_reset_q) begin
         gap_q <= '0;
      end else if (gap_q != 32'hFFFFFFFF) begin
         gap_q <= gap_q + 32'h1;
      end
   end
   AST_WR_PAIR: assert property (s_axi_awready == s_axi_wready) else $error("write readies split");
   AST_WR_RESP: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no write response");
   AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken while answering");
   AST_RD_RESP: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read response");
   AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_POP_IRQ: assert property (stack_pop_q |-> master_irq_enable_q ##1 !stack_pop_q)
      else $error("pop without irq enable");
   AST_HALT_QUIET: assert property (!osc_run_q |-> !watchdog_reset_q) else $error("watchdog pulse in halt");
   AST_WAKE: assert property (!osc_run_q && wake_evt |-> ##[1:4] osc_run_q) else $error("wake ignored");
   AST_WDOG_GAP: assert property (watchdog_reset_q |-> gap_q >= WATCHDOG_CYCLES - 1)
      else $error("watchdog expired early");
endmodule // cies_props

bind cies_core cies_props #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES)) u_props (
   .clk(clk), .rst_b(rst_b), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .wake_evt(wake_evt), .stack_pop_q(stack_pop_q),
   .master_irq_enable_q(master_irq_enable_q), .osc_run_q(osc_run_q), .watchdog_reset_q(watchdog_reset_q)
);

/* tb.sv */
// Purpose: Self-checking bench for the execution unit
// Assumes: Short settle and watchdog counts
// Notes: Handshakes sampled at the falling edge, driven after the rising edge
`include "cies_cfg.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wake_evt;
   logic stack_pop_q, master_irq_enable_q, osc_run_q, watchdog_reset_q;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [12:0] stack_head, pc_q;
   logic [7:0] k, a, v;
   logic [10:0] s;
   logic e_to, e_pd, e_z, e_dc, e_c;
   logic [15:0] cor [5] = '{16'h0201, 16'h0202, 16'h0203, 16'h00FF, 16'h1001};
   int n_fail, checked, seed, i;
   time t0;

   cies_core #(.WATCHDOG_CYCLES(50), .SUPPLY_SETTLE_CYCLES(20)) uut (
      .clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .stack_head(stack_head), .wake_evt(wake_evt), .stack_pop_q(stack_pop_q),
      .master_irq_enable_q(master_irq_enable_q), .osc_run_q(osc_run_q),
      .watchdog_reset_q(watchdog_reset_q), .pc_q(pc_q)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (n_fail == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic hang();
      chk(32'h0, 32'h1);
      conclude();
   endtask

   task automatic wr(input logic [4:0] ad, input logic [31:0] dt, input logic [3:0] st, output logic [1:0] rs);
      int n;
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (s_axi_awready !== 1'b1 && n < 100);
      @(posedge clk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      // Late ready on control writes makes the response wait
      if (ad == `CIES_CTRL_OFS) @(posedge clk);
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      rs = s_axi_bresp;
      @(posedge clk);
      s_axi_bready <= 1'b0;
      if (n >= 200) hang();
   endtask

   task automatic rd(input logic [4:0] ad, output logic [31:0] dt, output logic [1:0] rs);
      int n;
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 100);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      // Late ready on counter reads makes the data wait
      if (ad == `CIES_PC_OFS) @(posedge clk);
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 200);
      dt = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      s_axi_rready <= 1'b0;
      if (n >= 200) hang();
   endtask

   // Polls status until the masked bits match; long enough for the 1024-cycle settle
   task automatic wait_st(input logic [31:0] m, input logic [31:0] val);
      int n;
      logic [31:0] dt;
      logic [1:0] rs;
      n = 0;
      do begin
         rd(`CIES_STATUS_OFS, dt, rs);
         n++;
      end while ((dt & m) !== val && n < 600);
      if (n >= 600) hang();
   endtask

   function automatic logic [10:0] sub_exp(input logic [7:0] kk, input logic [7:0] aa);
      logic [7:0] res;
      res = kk - aa;
      return {res == 8'h00, kk[3:0] >= aa[3:0], kk >= aa, res};
   endfunction

   function automatic logic [31:0] st_exp();
      return {27'h0, e_to, e_pd, e_z, e_dc, e_c};
   endfunction

   task automatic op(input logic [13:0] code);
      wr(`CIES_INSTR_OFS, {18'h0, code}, 4'h3, r);
      wait_st(32'hE0, 32'h0);
   endtask

   initial begin
      #1000000;
      hang();
   end

   initial begin
      seed = 32'h0bba;
      n_fail = 0;
      checked = 0;
      rst_b = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, wake_evt} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = '0;
      stack_head = 13'($random(seed));
      {e_to, e_pd, e_z, e_dc, e_c} = 5'h18;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd(`CIES_STATUS_OFS, d, r);
      chk(d, 32'hB8);
      wr(`CIES_ACC_OFS, 32'h55, 4'h1, r);
      wait_st(32'hE0, 32'h0);
      rd(`CIES_ACC_OFS, d, r);
      chk(d, 32'h0);
      rd(`CIES_PRESCALE_CFG_OFS, d, r);
      chk(d, 32'hFF);
      rd(`CIES_PC_OFS, d, r);
      chk(d, 32'h0);
      rd(5'h18, d, r);
      chk({r, d[29:0]}, 32'h80000000);
      wr(5'h01, 32'h1, 4'h1, r);
      chk({30'h0, r}, 32'h2);
      v = 8'($random(seed));
      wr(`CIES_PRESCALE_CFG_OFS, {24'h0, v}, 4'h1, r);
      rd(`CIES_PRESCALE_CFG_OFS, d, r);
      chk(d, {24'h0, v});
      for (i = 0; i < 12; i++) begin
         {k, a} = (i < 5) ? cor[i] : 16'($random(seed));
         wr(`CIES_ACC_OFS, {24'h0, a}, 4'h1, r);
         op({`CIES_OP_LITSUB_HI, i[0], k});
         s = sub_exp(k, a);
         {e_z, e_dc, e_c} = s[10:8];
         rd(`CIES_ACC_OFS, d, r);
         chk(d, {24'h0, s[7:0]});
         rd(`CIES_STATUS_OFS, d, r);
         chk(d, st_exp());
      end
      // Upper opcode bits set: must not be taken for the config load
      wr(`CIES_ACC_OFS, 32'h5A, 4'h1, r);
      op(14'h0162);
      rd(`CIES_PRESCALE_CFG_OFS, d, r);
      chk(d, {24'h0, v});
      op(`CIES_OP_LOAD_CFG);
      rd(`CIES_PRESCALE_CFG_OFS, d, r);
      chk(d, 32'h5A);
      rd(`CIES_STATUS_OFS, d, r);
      chk(d, st_exp());
      op(`CIES_OP_RETURN_IRQ);
      rd(`CIES_PC_OFS, d, r);
      chk(d, {19'h0, stack_head});
      chk({19'h0, pc_q}, {19'h0, stack_head});
      chk({31'h0, master_irq_enable_q}, 32'h1);
      rd(`CIES_STATUS_OFS, d, r);
      chk(d, st_exp());
      wr(`CIES_INSTR_OFS, {18'h0, `CIES_OP_POWERDOWN}, 4'h3, r);
      wait_st(32'h40, 32'h40);
      e_pd = 1'b0;
      chk({31'h0, osc_run_q}, 32'h0);
      rd(`CIES_STATUS_OFS, d, r);
      chk(d[6:0], st_exp() | 32'h60);
      wake_evt <= 1'b1;
      wait_st(32'h40, 32'h0);
      t0 = $time;
      wake_evt <= 1'b0;
      wait_st(32'hE0, 32'h0);
      chk({31'h0, ($time - t0) >= 10150}, 32'h1);
      chk({31'h0, osc_run_q}, 32'h1);
      rd(`CIES_STATUS_OFS, d, r);
      chk(d, st_exp());
      wr(`CIES_CTRL_OFS, 32'h2, 4'h1, r);
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (watchdog_reset_q !== 1'b1 && i < 90);
      if (i >= 90) hang();
      chk({31'h0, i >= 45}, 32'h1);
      e_to = 1'b0;
      @(posedge clk);
      wr(`CIES_CTRL_OFS, 32'h0, 4'h1, r);
      rd(`CIES_STATUS_OFS, d, r);
      chk(d, st_exp());
      conclude();
   end
endmodule // tb
